// file: rtl/wkr_pkg.sv
// constants for the wake-up event interrupt register bank
// assumes a simple strobe register port clocked by clk_sys_i
package wkr_pkg;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] OFS_BASE_HIGH = 8'h0a;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h0c;
    localparam logic [7:0] OFS_HOST_STATUS = 8'h0e;
    localparam logic [7:0] OFS_WAKE_STATUS = 8'h20;
    localparam logic [7:0] OFS_CTRL = 8'h22;
    localparam logic [7:0] OFS_MON_STATUS = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h26;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h28;
    // ************************************************************
    // fields and reset values
    // ************************************************************
    localparam int BIT_MODULE = 7;
    localparam int BIT_SOFT = 6;
    localparam int BIT_RING = 3;
    localparam int BIT_RI2 = 1;
    localparam int BIT_RI1 = 0;
    localparam int BIT_SUPPLY_OFF = 7;
    localparam int BIT_PWRBUTTON = 6;
    localparam int BIT_ALARM = 0;
    localparam int BIT_CLEAR_MODE = 0;
    localparam int BIT_RING_MODE = 1;
    localparam int BIT_ADDR_VALID = 2;
    localparam logic [7:0] HOST_STATUS_MASK = 8'h00cb;
    localparam logic [7:0] RST_ZERO = 8'h0000;
    localparam logic [7:0] ADDR_VALID_MASK = 8'h0004;
endpackage

// file: rtl/wkr_regs.sv
// wake-up event and interrupt register bank
// assumes event inputs come from other clocks or pins and are synchronised
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
// How it works
// [RULE1] base high byte, offset 0x0a, reset 0
// [RULE2] enable register cleared on warm reset
// [RULE3] irq drops on status clear or disable
// [RULE4] bit 7 enables supply-off change irq
// [RULE5] bit 6 enables power-button change irq
// [RULE6] bits 5..1 enable sleep request irq
// [RULE7] bit 0 enables alarm rising irq
// [RULE8] host status mirrors wake status, shared clear
// [RULE9] host status cleared on power-up, soft reset
// [RULE10] bit 7 module event, write one clears
// [RULE11] mode 0: bit 6 on soft toggle
// [RULE12] mode 1: bit 6 on soft write
// [RULE13] bit 6 cleared by writing one
// [RULE14] ring flag, zero when ring mode off
// [RULE15] bits 1,0 ring-indicate two and one
// [RULE16] control bit selects soft clear mode
// [RULE17] address valid set by base high write
// [RULE18] write zero keeps; reserved reads zero
module wkr_regs (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic warm_rst_i,
    input wire logic host_soft_rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic supply_off_monitor_i,
    input wire logic pwrbutton_mode_monitor_i,
    input wire logic [4:0] sleep_req_monitor_i,
    input wire logic alarm_active_flag_i,
    input wire logic module_irq_i,
    input wire logic ring_detect_i,
    input wire logic ring_ind_two_i,
    input wire logic ring_ind_one_i,
    output logic wake_irq_o,
    output logic evt_irq_o
);
    import wkr_pkg::*;

    // ************************************************************
    // input synchronisers
    // ************************************************************
    localparam int NSYNC = 14;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync1_ff;
    logic [NSYNC-1:0] sync2_ff;
    logic [NSYNC-1:0] prev_ff;
    logic [NSYNC-1:0] rise;
    logic [NSYNC-1:0] chg;

    assign raw_in = {supply_off_monitor_i, pwrbutton_mode_monitor_i,
                     sleep_req_monitor_i, alarm_active_flag_i,
                     module_irq_i, ring_detect_i, ring_ind_two_i,
                     ring_ind_one_i, warm_rst_i, host_soft_rst_i};

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            prev_ff <= '0;
        end else begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end
    assign rise = sync2_ff & ~prev_ff;
    assign chg = sync2_ff ^ prev_ff;

    logic [7:0] mon_chg;
    logic alarm_rise;
    logic module_evt;
    logic ring_evt;
    logic ri2_evt;
    logic ri1_evt;
    logic warm_rst;
    logic soft_rst;
    // monitors and alarm packed in the enable register layout
    assign mon_chg = {chg[13], chg[12], chg[11:7], 1'b0}; // see [RULE6]
    assign alarm_rise = rise[6]; // see [RULE7]
    assign module_evt = rise[5];
    assign ring_evt = rise[4];
    assign ri2_evt = rise[3];
    assign ri1_evt = rise[2];
    assign warm_rst = sync2_ff[1];
    assign soft_rst = sync2_ff[0];

    // ************************************************************
    // write decode
    // ************************************************************
    logic wr_base;
    logic wr_en;
    logic wr_host;
    logic wr_wake;
    logic wr_ctrl;
    logic wr_mon;
    logic wr_mask;
    logic wr_ists;
    assign wr_base = reg_wr_i && reg_addr_i == OFS_BASE_HIGH;
    assign wr_en = reg_wr_i && reg_addr_i == OFS_IRQ_ENABLE;
    assign wr_host = reg_wr_i && reg_addr_i == OFS_HOST_STATUS;
    assign wr_wake = reg_wr_i && reg_addr_i == OFS_WAKE_STATUS;
    assign wr_ctrl = reg_wr_i && reg_addr_i == OFS_CTRL;
    assign wr_mon = reg_wr_i && reg_addr_i == OFS_MON_STATUS;
    assign wr_mask = reg_wr_i && reg_addr_i == OFS_IRQ_MASK;
    assign wr_ists = reg_wr_i && reg_addr_i == OFS_IRQ_STATUS;

    // ************************************************************
    // base address and control
    // ************************************************************
    logic [7:0] base_upper_byte_ff;
    logic [7:0] ctrl_ff;
    logic soft_event_clear_mode;
    logic ring_mode;
    assign soft_event_clear_mode = ctrl_ff[BIT_CLEAR_MODE]; // see [RULE16]
    assign ring_mode = ctrl_ff[BIT_RING_MODE];

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            base_upper_byte_ff <= RST_ZERO;
        end else if (wr_base) begin
            base_upper_byte_ff <= reg_wdata_i; // see [RULE1]
        end
    end

    // valid flag: set by base write wins over write-one clear
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_ff <= RST_ZERO;
        end else if (wr_base) begin
            ctrl_ff[BIT_ADDR_VALID] <= 1'b1; // see [RULE17]
            if (wr_ctrl) begin
                ctrl_ff[1:0] <= reg_wdata_i[1:0];
            end
        end else if (wr_ctrl) begin
            ctrl_ff[1:0] <= reg_wdata_i[1:0];
            if (reg_wdata_i[BIT_ADDR_VALID]) begin
                ctrl_ff[BIT_ADDR_VALID] <= 1'b0;
            end
        end
    end

    // ************************************************************
    // enable and monitor change status
    // ************************************************************
    logic [7:0] wake_irq_enable_ff;
    logic [7:0] mon_sts_ff;
    logic wake_irq_ff;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wake_irq_enable_ff <= RST_ZERO;
        end else if (warm_rst) begin
            wake_irq_enable_ff <= RST_ZERO; // see [RULE2]
        end else if (wr_en) begin
            wake_irq_enable_ff <= reg_wdata_i;
        end
    end

    // change latches; set wins over write-one clear
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mon_sts_ff <= RST_ZERO;
        end else begin
            mon_sts_ff <= (mon_sts_ff & ~({8{wr_mon}} & reg_wdata_i))
                          | mon_chg | {7'b0, alarm_rise}; // see [RULE18]
        end
    end

    // level irq: status and enable, drops on either cleared
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wake_irq_ff <= 1'b0;
        end else begin
            wake_irq_ff <= |(mon_sts_ff & wake_irq_enable_ff); // see [RULE3]
        end
    end
    // per-source gating in the or-reduce above: see [RULE4] [RULE5]
    // see [RULE6] [RULE7]

    // ************************************************************
    // host event status, shared with the wake status view
    // ************************************************************
    logic [7:0] host_event_status_ff;
    logic [7:0] nxt_host_status;
    logic [7:0] host_set;
    logic [7:0] host_clr;
    logic soft_prev_ff;
    logic soft_set;

    // soft flag set by writing one to the wake view soft bit
    assign soft_set = wr_wake && reg_wdata_i[BIT_SOFT] &&
                      (soft_event_clear_mode || !soft_prev_ff);
    // see [RULE11] [RULE12]

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            soft_prev_ff <= 1'b0;
        end else if (wr_wake && reg_wdata_i[BIT_SOFT]) begin
            soft_prev_ff <= 1'b1;
        end else if (!host_event_status_ff[BIT_SOFT]) begin
            soft_prev_ff <= 1'b0;
        end
    end

    always_comb begin
        host_set = RST_ZERO;
        host_set[BIT_MODULE] = module_evt; // see [RULE10]
        host_set[BIT_SOFT] = soft_set;
        host_set[BIT_RING] = ring_evt & ring_mode; // see [RULE14]
        host_set[BIT_RI2] = ri2_evt; // see [RULE15]
        host_set[BIT_RI1] = ri1_evt;
        host_clr = ({8{wr_host}} & reg_wdata_i); // see [RULE13]
        if (wr_wake) begin
            host_clr = host_clr | (reg_wdata_i & ~8'h0040);
        end
        // see [RULE8]
        nxt_host_status = ((host_event_status_ff & ~host_clr) | host_set)
                          & HOST_STATUS_MASK;
        if (!ring_mode) begin
            nxt_host_status[BIT_RING] = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            host_event_status_ff <= RST_ZERO;
        end else if (soft_rst) begin
            host_event_status_ff <= RST_ZERO; // see [RULE9]
        end else begin
            host_event_status_ff <= nxt_host_status;
        end
    end

    // ************************************************************
    // interrupt summary for host events
    // ************************************************************
    logic [7:0] irq_mask_ff;
    logic [7:0] irq_sts_ff;
    logic evt_irq_ff;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_mask_ff <= RST_ZERO;
        end else if (wr_mask) begin
            irq_mask_ff <= reg_wdata_i & HOST_STATUS_MASK;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_sts_ff <= RST_ZERO;
        end else begin
            irq_sts_ff <= (irq_sts_ff & ~({8{wr_ists}} & reg_wdata_i))
                          | host_set;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            evt_irq_ff <= 1'b0;
        end else begin
            evt_irq_ff <= |(irq_sts_ff & irq_mask_ff);
        end
    end

    // ************************************************************
    // read port
    // ************************************************************
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr_i)
            OFS_BASE_HIGH: rd_mux = base_upper_byte_ff;
            OFS_IRQ_ENABLE: rd_mux = wake_irq_enable_ff;
            OFS_HOST_STATUS: rd_mux = host_event_status_ff;
            OFS_WAKE_STATUS: rd_mux = host_event_status_ff;
            OFS_CTRL: rd_mux = ctrl_ff & (ADDR_VALID_MASK | 8'h0003);
            OFS_MON_STATUS: rd_mux = mon_sts_ff;
            OFS_IRQ_MASK: rd_mux = irq_mask_ff;
            OFS_IRQ_STATUS: rd_mux = irq_sts_ff;
            default: rd_mux = RST_ZERO;
        endcase
    end

    logic [7:0] rdata_ff;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_ff <= RST_ZERO;
        end else if (reg_rd_i) begin
            rdata_ff <= rd_mux;
        end else begin
            rdata_ff <= RST_ZERO;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign wake_irq_o = wake_irq_ff;
    assign evt_irq_o = evt_irq_ff;

    // ************************************************************
    // checks
    // ************************************************************
    warm_clears_en_a: assert property (@(posedge clk_sys_i) // see [RULE2]
        disable iff (!nrst_i) warm_rst |=> wake_irq_enable_ff == 8'h0000)
        else $error("enable not cleared by warm reset");
    irq_follows_a: assert property (@(posedge clk_sys_i) // see [RULE3]
        disable iff (!nrst_i)
        (|(mon_sts_ff & wake_irq_enable_ff)) |=> wake_irq_o)
        else $error("wake irq mismatch");
    irq_drops_a: assert property (@(posedge clk_sys_i) // see [RULE3]
        disable iff (!nrst_i)
        !(|(mon_sts_ff & wake_irq_enable_ff)) |=> !wake_irq_o)
        else $error("wake irq stuck high");
    base_write_a: assert property (@(posedge clk_sys_i) // see [RULE1]
        disable iff (!nrst_i)
        wr_base |=> base_upper_byte_ff == $past(reg_wdata_i))
        else $error("base byte not stored");
    valid_set_a: assert property (@(posedge clk_sys_i) // see [RULE17]
        disable iff (!nrst_i) wr_base |=> ctrl_ff[BIT_ADDR_VALID])
        else $error("valid flag not set");
    soft_rst_a: assert property (@(posedge clk_sys_i) // see [RULE9]
        disable iff (!nrst_i) soft_rst |=> host_event_status_ff == 8'h0000)
        else $error("host status not cleared");
    ring_off_a: assert property (@(posedge clk_sys_i) // see [RULE14]
        disable iff (!nrst_i)
        !$past(ring_mode) |-> !host_event_status_ff[BIT_RING])
        else $error("ring flag set while off");
    reserved_zero_a: assert property (@(posedge clk_sys_i) // see [RULE18]
        disable iff (!nrst_i) (host_event_status_ff & 8'h0034) == 8'h0000)
        else $error("reserved bit set");
    module_evt_a: assert property (@(posedge clk_sys_i) // see [RULE10]
        disable iff (!nrst_i)
        module_evt && !soft_rst |=> host_event_status_ff[BIT_MODULE])
        else $error("module event lost");
    soft_mode_a: assert property (@(posedge clk_sys_i) // see [RULE12]
        disable iff (!nrst_i)
        wr_wake && reg_wdata_i[BIT_SOFT] && soft_event_clear_mode
        && !soft_rst |=> host_event_status_ff[BIT_SOFT])
        else $error("soft flag not set");
    read_data_a: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i) reg_rd_i |=> reg_rdata_o == $past(rd_mux))
        else $error("read data wrong");
    supply_chg_a: assert property (@(posedge clk_sys_i) // see [RULE4]
        disable iff (!nrst_i)
        $changed(supply_off_monitor_i) |-> ##3 mon_sts_ff[BIT_SUPPLY_OFF])
        else $error("supply-off change lost");
    button_chg_a: assert property (@(posedge clk_sys_i) // see [RULE5]
        disable iff (!nrst_i)
        $changed(pwrbutton_mode_monitor_i) |-> ##3 mon_sts_ff[BIT_PWRBUTTON])
        else $error("power-button change lost");
    sleep_chg_a: assert property (@(posedge clk_sys_i) // see [RULE6]
        disable iff (!nrst_i)
        $changed(sleep_req_monitor_i) |-> ##3 mon_sts_ff[5:1] != 5'h00)
        else $error("sleep request change lost");
    alarm_rise_a: assert property (@(posedge clk_sys_i) // see [RULE7]
        disable iff (!nrst_i)
        $rose(alarm_active_flag_i) |-> ##3 mon_sts_ff[BIT_ALARM])
        else $error("alarm rise lost");
    ring_set_a: assert property (@(posedge clk_sys_i) // see [RULE14]
        disable iff (!nrst_i)
        ring_evt && ring_mode && !soft_rst |=> host_event_status_ff[BIT_RING])
        else $error("ring event lost");
    ri_set_a: assert property (@(posedge clk_sys_i) // see [RULE15]
        disable iff (!nrst_i)
        ri1_evt && !soft_rst |=> host_event_status_ff[BIT_RI1])
        else $error("ring-indicate event lost");
    soft_clear_a: assert property (@(posedge clk_sys_i) // see [RULE13]
        disable iff (!nrst_i)
        wr_host && reg_wdata_i[BIT_SOFT] |=> !host_event_status_ff[BIT_SOFT])
        else $error("soft flag not cleared");
    evt_irq_a: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        (|(irq_sts_ff & irq_mask_ff)) |=> evt_irq_o)
        else $error("event irq not raised");
endmodule

// file: test/wkr_regs_test.sv
// self-checking bench for the wake-up event interrupt register bank
// assumes wkr_pkg offsets; the bench drives every input port of wkr_regs itself
`timescale 1ns/1ps
module wkr_regs_test;
    import wkr_pkg::*;
    // ************************************************************
    // stimulus and design
    // ************************************************************
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic warm_rst_i = 1'b0;
    logic host_soft_rst_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic [7:0] mon_src = 8'h00;
    logic [3:0] ev_src = 4'h0;
    logic wake_irq_o;
    logic evt_irq_o;
    int err_total = 0;
    int comparisons = 0;
    logic [31:0] rnd = 32'h0000_51b4;
    logic [7:0] m_base, m_en, m_host, m_mon, m_ctrl, bitv;
    int ev_bit [4] = '{0, 1, 3, 7};
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    wkr_regs wkr_regs_inst (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .warm_rst_i(warm_rst_i),
        .host_soft_rst_i(host_soft_rst_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .supply_off_monitor_i(mon_src[7]),
        .pwrbutton_mode_monitor_i(mon_src[6]),
        .sleep_req_monitor_i(mon_src[5:1]),
        .alarm_active_flag_i(mon_src[0]),
        .module_irq_i(ev_src[3]),
        .ring_detect_i(ev_src[2]),
        .ring_ind_two_i(ev_src[1]),
        .ring_ind_one_i(ev_src[0]),
        .wake_irq_o(wake_irq_o),
        .evt_irq_o(evt_irq_o)
    );
    // ************************************************************
    // tasks
    // ************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(reg_rdata_o, exp);
    endtask
    task automatic irqs(input logic w, input logic e);
        wt(3);
        #1;
        chk({7'h00, wake_irq_o}, {7'h00, w});
        chk({7'h00, evt_irq_o}, {7'h00, e});
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        #400000;
        err_total++;
        end_sim();
    end
    initial begin
        m_base = 8'h00; m_en = 8'h00; m_host = 8'h00;
        m_mon = 8'h00; m_ctrl = 8'h00;
        wt(3);
        nrst_i <= 1'b1;
        rd(OFS_BASE_HIGH, m_base);
        rd(OFS_IRQ_ENABLE, m_en);
        rd(OFS_HOST_STATUS, m_host);
        rd(OFS_CTRL, m_ctrl);
        rd(8'h30, 8'h00);
        rnd = lfsr(rnd);
        m_base = rnd[7:0];
        wr(OFS_BASE_HIGH, m_base);
        m_ctrl[BIT_ADDR_VALID] = 1'b1;
        rd(OFS_BASE_HIGH, m_base);
        rd(OFS_CTRL, m_ctrl);
        wr(8'h30, 8'hff);
        rd(8'h30, 8'h00);
        // each monitor source: set, hold on write 0, mask, then clear
        for (int i = 0; i < 8; i++) begin
            bitv = 8'h01 << i;
            wr(OFS_IRQ_ENABLE, bitv);
            rd(OFS_IRQ_ENABLE, bitv);
            irqs(1'b0, 1'b0);
            mon_src[i] <= ~mon_src[i];
            wt(6);
            rd(OFS_MON_STATUS, bitv);
            irqs(1'b1, 1'b0);
            wr(OFS_MON_STATUS, 8'h00);
            rd(OFS_MON_STATUS, bitv);
            wr(OFS_IRQ_ENABLE, 8'h00);
            irqs(1'b0, 1'b0);
            wr(OFS_IRQ_ENABLE, bitv);
            irqs(1'b1, 1'b0);
            wr(OFS_MON_STATUS, bitv);
            irqs(1'b0, 1'b0);
        end
        mon_src[0] <= 1'b0;
        wt(6);
        rd(OFS_MON_STATUS, 8'h00);
        // host events; ring flag first with ring mode off
        ev_src[2] <= 1'b1;
        wt(6);
        rd(OFS_HOST_STATUS, 8'h00);
        ev_src[2] <= 1'b0;
        m_ctrl[BIT_RING_MODE] = 1'b1;
        wr(OFS_CTRL, m_ctrl & 8'h03);
        wt(4);
        for (int j = 0; j < 4; j++) begin
            ev_src[j] <= 1'b1;
            wt(6);
            m_host[ev_bit[j]] = 1'b1;
            rd(OFS_HOST_STATUS, m_host);
            rd(OFS_WAKE_STATUS, m_host);
        end
        wr(OFS_IRQ_MASK, 8'h80);
        irqs(1'b0, 1'b1);
        wr(OFS_IRQ_MASK, 8'h00);
        irqs(1'b0, 1'b0);
        wr(OFS_IRQ_STATUS, 8'hff);
        ev_src <= 4'h0;
        wr(OFS_HOST_STATUS, 8'h00);
        rd(OFS_HOST_STATUS, m_host);
        wr(OFS_HOST_STATUS, 8'h8a);
        wr(OFS_WAKE_STATUS, 8'h01);
        m_host = 8'h00;
        rd(OFS_HOST_STATUS, m_host);
        wr(OFS_HOST_STATUS, 8'h34);
        rd(OFS_HOST_STATUS, 8'h00);
        // software event in both clear modes
        // a repeat request while the flag stands is an event only in mode 1
        for (int k = 0; k < 2; k++) begin
            m_ctrl[BIT_CLEAR_MODE] = k[0];
            wr(OFS_CTRL, m_ctrl & 8'h03);
            rd(OFS_CTRL, m_ctrl);
            wr(OFS_WAKE_STATUS, 8'h40);
            rd(OFS_HOST_STATUS, 8'h40);
            wr(OFS_IRQ_STATUS, 8'hff);
            wr(OFS_WAKE_STATUS, 8'h40);
            rd(OFS_IRQ_STATUS, {1'b0, k[0], 6'h00});
            wr(OFS_HOST_STATUS, 8'h40);
            rd(OFS_HOST_STATUS, 8'h00);
        end
        wr(OFS_WAKE_STATUS, 8'h40);
        rd(OFS_HOST_STATUS, 8'h40);
        host_soft_rst_i <= 1'b1;
        wt(4);
        host_soft_rst_i <= 1'b0;
        wt(3);
        rd(OFS_HOST_STATUS, 8'h00);
        rnd = lfsr(rnd);
        wr(OFS_IRQ_ENABLE, rnd[7:0] | 8'h01);
        warm_rst_i <= 1'b1;
        wt(4);
        warm_rst_i <= 1'b0;
        wt(3);
        rd(OFS_IRQ_ENABLE, 8'h00);
        // valid flag is write-one-to-clear
        wr(OFS_CTRL, m_ctrl);
        m_ctrl[BIT_ADDR_VALID] = 1'b0;
        rd(OFS_CTRL, m_ctrl);
        // second power-up in mid-run
        nrst_i <= 1'b0;
        wt(3);
        nrst_i <= 1'b1;
        rd(OFS_BASE_HIGH, 8'h00);
        rd(OFS_CTRL, 8'h00);
        rd(OFS_HOST_STATUS, 8'h00);
        end_sim();
    end
endmodule
